// File: tb/test_tweew_slave.sv
// self-checking bench for the two-wire eeprom slave write block
`timescale 1ns/1ps
module test_tweew_slave;
	reg         clock = 1'h0;
	reg         rst = 1'h1;
	reg  [2:0]  cs = 3'h6;
	reg         wp = 1'h0;
	reg         rdy = 1'h1;
	wire        scl, sda_m, sda, sda_out, sda_oe, valid, busy, rsel;
	wire [7:0]  waddr, wdata, ptr;
	reg  [15:0] got [$];
	integer     mismatches = 0;
	integer     n_compared = 0;
	integer     i, j;
	reg         ack;
	always #50 clock = ~clock;
	// open-drain data wire with pull-up
	assign sda = sda_m & ~(sda_oe & ~sda_out);
	tweew_mst m (.clock(clock), .scl(scl), .sda_m(sda_m), .sda(sda));
	tweew_slave #(.TWC_CYCLES(200)) dut (.clock(clock), .rst(rst),
		.scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
		.chip_select_pin_0(cs[0]), .chip_select_pin_1(cs[1]),
		.chip_select_pin_2(cs[2]), .write_protect(wp), .mem_wr_addr(waddr),
		.mem_wr_data(wdata), .mem_wr_valid(valid), .mem_wr_ready(rdy),
		.addr_ptr(ptr), .write_busy(busy), .read_selected(rsel));
	// collect array words as they transfer
	always @(posedge clock) if (valid && rdy) got.push_back({waddr, wdata});
	task chk(input [15:0] a, input [15:0] e);
		begin
			n_compared = n_compared + 1;
			if (a !== e) begin
				mismatches = mismatches + 1;
				$display("MISMATCH %0t got %h want %h", $time, a, e);
			end
		end
	endtask
	task complete_run;
		begin
			$display("compared %0d mismatches %0d", n_compared, mismatches);
			if (mismatches == 0 && n_compared > 0)
				$display("Regression OK");
			else
				$display("Regression broken");
			$finish;
		end
	endtask
	// one control byte, expected acknowledge, then stop
	task ctl(input [7:0] c, input e);
		begin
			m.start;
			m.send(c, ack);
			chk({15'h0, ack}, {15'h0, e});
			m.stop;
		end
	endtask
	// write: control, word address, n bytes counting from d
	task tx(input [7:0] a, input integer n, input [7:0] d);
		begin
			m.start;
			m.send(8'hAC, ack);
			chk({15'h0, ack}, 16'h1);
			m.send(a, ack);
			chk({ack, 7'h0, ptr}, {1'h1, 7'h0, a});
			for (j = 0; j < n; j = j + 1) begin
				m.send(d + j[7:0], ack);
				chk({15'h0, ack}, 16'h1);
			end
			m.stop;
		end
	endtask
	// wait out the write cycle, then count stored words
	task drain(input integer n);
		begin
			j = 0;
			while (busy !== 1'h0 && j < 1000) begin
				@(posedge clock);
				j = j + 1;
			end
			chk(16'(got.size()), 16'(n));
			if (j == 1000) begin
				mismatches = mismatches + 1;
				complete_run;
			end
		end
	endtask
	initial begin
		repeat (4) @(posedge clock);
		rst <= 1'h0;
		repeat (4) @(posedge clock);
		ctl(8'hBC, 1'h0);
		ctl(8'hA6, 1'h0);
		// three bytes with the array stalled meanwhile
		rdy <= 1'h0;
		tx(8'h35, 3, 8'h61);
		ctl(8'hAC, 1'h0);
		chk({15'h0, busy}, 16'h1);
		rdy <= 1'h1;
		drain(3);
		for (i = 0; i < 3; i = i + 1)
			chk(got[i], 16'(16'h3561 + 16'h0101 * i));
		ctl(8'hAC, 1'h1);
		got.delete();
		// eighteen bytes from offset E: wrap, last sixteen kept
		tx(8'h3E, 18, 8'h40);
		drain(16);
		for (i = 0; i < 16; i = i + 1) begin
			j = (i + 2) % 16;
			if (j < 2)
				j = j + 16;
			chk(got[i], 16'(16'h3040 + 16'h0100 * i + j));
		end
		got.delete();
		// protected write is acknowledged and timed, stores nothing
		wp <= 1'h1;
		tx(8'h80, 1, 8'h11);
		chk({15'h0, busy}, 16'h1);
		drain(0);
		wp <= 1'h0;
		m.start;
		m.send(8'hAD, ack);
		chk({14'h0, ack, rsel}, 16'h3);
		m.stop;
		complete_run;
	end
	// watchdog well past the expected run length
	initial begin
		#3000000;
		mismatches = mismatches + 1;
		complete_run;
	end
endmodule // test_tweew_slave

// File: tb/tweew_mst.sv
// bus master model driving the two-wire clock and data
`timescale 1ns/1ps
module tweew_mst (
	clock,
	scl,
	sda_m,
	sda
);
	input  wire clock;
	output reg  scl = 1'h1;
	output reg  sda_m = 1'h1;
	input  wire sda;
	// wait some system clocks, changes land just after an edge
	task w(input integer n);
		repeat (n) @(posedge clock);
	endtask
	// one clock pulse, data already set while clock low
	task pulse;
		begin
			w(4);
			scl <= 1'h1;
			w(4);
			scl <= 1'h0;
			w(1);
		end
	endtask
	// start from idle or repeated start
	task start;
		begin
			sda_m <= 1'h1;
			scl <= 1'h1;
			w(4);
			sda_m <= 1'h0;
			w(4);
			scl <= 1'h0;
			w(1);
		end
	endtask
	// stop ends every operation
	task stop;
		begin
			sda_m <= 1'h0;
			w(4);
			scl <= 1'h1;
			w(4);
			sda_m <= 1'h1;
			w(4);
		end
	endtask
	// msb first, then release for the ninth clock
	task send(input [7:0] b, output ack);
		integer i;
		begin
			for (i = 7; i >= 0; i = i - 1) begin
				sda_m <= b[i];
				pulse;
			end
			sda_m <= 1'h1;
			w(4);
			scl <= 1'h1;
			w(1);
			ack = !sda;
			w(3);
			ack = ack & !sda;
			scl <= 1'h0;
			w(1);
		end
	endtask
endmodule // tweew_mst

// File: tb/tweew_slave_chk.sv
// checker for the two-wire eeprom slave write block
`timescale 1ns/1ps
module tweew_slave_chk (
	clock,
	rst,
	scl_in,
	sda_in,
	sda_out,
	sda_oe,
	mem_wr_addr,
	mem_wr_data,
	mem_wr_valid,
	mem_wr_ready,
	addr_ptr,
	write_busy
);
	input wire       clock;
	input wire       rst;
	input wire       scl_in;
	input wire       sda_in;
	input wire       sda_out;
	input wire       sda_oe;
	input wire [7:0] mem_wr_addr;
	input wire [7:0] mem_wr_data;
	input wire       mem_wr_valid;
	input wire       mem_wr_ready;
	input wire [7:0] addr_ptr;
	input wire       write_busy;
	// one clock domain, reset disables all
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	AST_OE_LOW: assert property (sda_oe |-> !sda_out)
		else $error("ack drives a high level");
	AST_ACK_RISE: assert property ($rose(sda_oe) |-> !scl_in)
		else $error("ack starts with clock high");
	AST_ACK_FALL: assert property ($fell(sda_oe) |-> !scl_in)
		else $error("ack ends with clock high");
	AST_NO_ACK_BUSY: assert property ($rose(sda_oe) |-> !write_busy)
		else $error("ack during write cycle");
	AST_HOLD: assert property (mem_wr_valid && !mem_wr_ready
		|=> mem_wr_valid && $stable({mem_wr_addr, mem_wr_data}))
		else $error("stalled word changed");
	AST_PAGE_HI: assert property (mem_wr_valid
		|-> mem_wr_addr[7:4] == addr_ptr[7:4])
		else $error("word left its page");
	AST_VALID_BUSY: assert property (mem_wr_valid |-> write_busy)
		else $error("word outside write cycle");
	AST_BUSY_STOP: assert property ($rose(write_busy) |-> scl_in && sda_in)
		else $error("write cycle without stop");
	AST_BUSY_MIN: assert property ($rose(write_busy) |=> write_busy[*8])
		else $error("write cycle too short");
endmodule // tweew_slave_chk

bind tweew_slave tweew_slave_chk chk (.clock, .rst, .scl_in, .sda_in, .sda_out,
	.sda_oe, .mem_wr_addr, .mem_wr_data, .mem_wr_valid, .mem_wr_ready,
	.addr_ptr, .write_busy);

// File: verilog/tweew_buf2.v
// two-entry valid/ready buffer
`timescale 1ns/1ps
module tweew_buf2 #(
	parameter WIDTH = 12
) (
	clock,
	rst,
	in_data,
	in_valid,
	in_ready,
	out_data,
	out_valid,
	out_ready
);
	input  wire             clock;
	input  wire             rst;
	input  wire [WIDTH-1:0] in_data;
	input  wire             in_valid;
	output wire             in_ready;
	output wire [WIDTH-1:0] out_data;
	output wire             out_valid;
	input  wire             out_ready;

	reg [WIDTH-1:0] head_reg;
	reg [WIDTH-1:0] skid_reg;
	reg             head_v_reg;
	reg             skid_v_reg;

	wire push;
	wire pop;
	// output side comes straight from the head entry flops
	assign in_ready  = ~skid_v_reg;
	assign out_valid = head_v_reg;
	assign out_data  = head_reg;
	assign push      = in_valid & ~skid_v_reg;
	assign pop       = head_v_reg & out_ready;

	// head feeds the output, skid catches a word that lands during a stall
	always @(posedge clock) begin
		if (rst) begin
			head_v_reg <= 1'h0;
			skid_v_reg <= 1'h0;
		end else if (~head_v_reg | pop) begin
			if (skid_v_reg) begin
				head_reg   <= skid_reg;
				head_v_reg <= 1'h1;
				skid_v_reg <= 1'h0;
			end else begin
				head_reg   <= in_data;
				head_v_reg <= push;
			end
		end else if (push) begin
			skid_reg   <= in_data;
			skid_v_reg <= 1'h1;
		end
	end
endmodule // tweew_buf2

// File: verilog/tweew_map.vh
// constants for the two-wire eeprom slave write block
`ifndef TWEEW_MAP_VH
`define TWEEW_MAP_VH
`define TWEEW_CTRL_CODE      4'hA
`define TWEEW_PAGE_BYTES     16
`define TWEEW_PAGE_BITS      4
`define TWEEW_ADDR_BITS      8
`define TWEEW_CLK_HZ         10000000
`define TWEEW_TWC_MS         5
`define TWEEW_TWC_CYCLES     ((`TWEEW_TWC_MS * `TWEEW_CLK_HZ) / 1000)
`define TWEEW_BIT_READ       1'h1
`endif

// File: verilog/tweew_slave.v
// two-wire eeprom slave: conditions, addressing, ack, page write, write cycle
// Functional notes
// - both lines high means bus idle
// - data falls while clock high: start
// - data rises while clock high: stop
// - data sampled on clock rise, one bit
// - ninth clock carries the acknowledge
// - ack holds data low over clock high
// - master nack ends read, line released
// - no acknowledge during programming cycle
// - first byte: control code 1010 required
// - chip-select bits must match pins
// - last control bit: one read, zero write
// - ack control, load pointer, ack it
// - stop after data starts write cycle
// - up to sixteen bytes buffered until stop
// - page bytes advance only low four bits
// - over sixteen bytes: wrap, keep last sixteen
// - protect pin high: ack, store nothing
// - protected write still runs write cycle
// - pointer never advances into other device
// - write cycle ends within five ms; here busy also holds until the array has taken every word
// - pointer wraps from FF to 00; here only the low four bits advance, so FF goes to F0
`timescale 1ns/1ps
`include "tweew_map.vh"
module tweew_slave #(
	parameter TWC_CYCLES = `TWEEW_TWC_CYCLES
) (
	clock,
	rst,
	scl_in,
	sda_in,
	sda_out,
	sda_oe,
	chip_select_pin_0,
	chip_select_pin_1,
	chip_select_pin_2,
	write_protect,
	mem_wr_addr,
	mem_wr_data,
	mem_wr_valid,
	mem_wr_ready,
	addr_ptr,
	write_busy,
	read_selected
);
	input  wire        clock;
	input  wire        rst;
	input  wire        scl_in;
	input  wire        sda_in;
	output reg         sda_out;
	output reg         sda_oe;
	input  wire        chip_select_pin_0;
	input  wire        chip_select_pin_1;
	input  wire        chip_select_pin_2;
	input  wire        write_protect;
	output wire [7:0]  mem_wr_addr;
	output wire [7:0]  mem_wr_data;
	output wire        mem_wr_valid;
	input  wire        mem_wr_ready;
	output reg  [7:0]  addr_ptr; // eight bits wide, but only the low four bits advance, so FF wraps to F0
	output reg         write_busy;
	output reg         read_selected;

	// phase states, one-hot
	localparam ST_IDLE = 5'h01;
	localparam ST_CTRL = 5'h02;
	localparam ST_ADDR = 5'h04;
	localparam ST_DATA = 5'h08;
	localparam ST_WAIT = 5'h10;

	// commit states, one-hot
	localparam CM_IDLE = 3'h1;
	localparam CM_PUSH = 3'h2;
	localparam CM_TIME = 3'h4;

	// pin copies after two flops
	wire scl_s;
	wire sda_s;
	wire wp_s;
	wire cs0_s;
	wire cs1_s;
	wire cs2_s;

	// every bus line, the protect pin and each chip-select pin is asynchronous: two flops before any logic reads it
	tweew_sync u_sync_scl (
		.clock (clock),
		.rst   (rst),
		.din   (scl_in),
		.dout  (scl_s)
	);
	tweew_sync u_sync_sda (
		.clock (clock),
		.rst   (rst),
		.din   (sda_in),
		.dout  (sda_s)
	);
	tweew_sync u_sync_wp (
		.clock (clock),
		.rst   (rst),
		.din   (write_protect),
		.dout  (wp_s)
	);
	tweew_sync u_sync_cs0 (
		.clock (clock),
		.rst   (rst),
		.din   (chip_select_pin_0),
		.dout  (cs0_s)
	);
	tweew_sync u_sync_cs1 (
		.clock (clock),
		.rst   (rst),
		.din   (chip_select_pin_1),
		.dout  (cs1_s)
	);
	tweew_sync u_sync_cs2 (
		.clock (clock),
		.rst   (rst),
		.din   (chip_select_pin_2),
		.dout  (cs2_s)
	);

	reg        scl_d_reg;
	reg        sda_d_reg;
	reg [4:0]  state_reg;
	reg [3:0]  bit_cnt_reg;
	reg [7:0]  shift_reg;
	reg        ack_phase_reg;
	reg        ack_drive_reg;
	reg [7:0]  page_mem [0:15];
	reg [15:0] page_valid_reg;
	reg [3:0]  page_base_reg;
	reg        got_data_reg;
	reg        wp_latched_reg;
	reg [2:0]  cm_reg;
	reg [3:0]  cm_idx_reg;
	reg [31:0] twc_cnt_reg;

	wire scl_rise;
	wire scl_fall;
	wire start_det;
	wire stop_det;
	wire [7:0] byte_now;
	wire ctrl_match;
	wire buf_in_ready;
	wire push_now;

	// byte assembled from the shift register and the eighth bit
	function [7:0] tweew_shift_in;
		input [7:0] cur;
		input       bitv;
		begin
			tweew_shift_in = {cur[6:0], bitv};
		end
	endfunction

	// edge and condition detection on synchronised lines
	assign scl_rise  = scl_s & ~scl_d_reg;
	assign scl_fall  = ~scl_s & scl_d_reg;
	assign start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
	assign stop_det  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
	assign byte_now  = tweew_shift_in(shift_reg, sda_s);
	// code and chip-select compare
	assign ctrl_match = (byte_now[7:4] == `TWEEW_CTRL_CODE) &
		(byte_now[3:1] == {cs2_s, cs1_s, cs0_s});

	// line history
	always @(posedge clock) begin
		if (rst) begin
			scl_d_reg <= 1'h1;
			sda_d_reg <= 1'h1;
		end else begin
			scl_d_reg <= scl_s;
			sda_d_reg <= sda_s;
		end
	end

	// byte receiver and protocol phase machine
	always @(posedge clock) begin
		if (rst) begin
			state_reg      <= ST_IDLE;
			bit_cnt_reg    <= 4'h0;
			shift_reg      <= 8'h00;
			ack_phase_reg  <= 1'h0;
			ack_drive_reg  <= 1'h0;
			addr_ptr       <= 8'h00;
			page_valid_reg <= 16'h0000;
			page_base_reg  <= 4'h0;
			got_data_reg   <= 1'h0;
			wp_latched_reg <= 1'h0;
			read_selected  <= 1'h0;
		end else if (start_det) begin
			state_reg     <= ST_CTRL;
			bit_cnt_reg   <= 4'h0;
			ack_phase_reg <= 1'h0;
			ack_drive_reg <= 1'h0;
			read_selected <= 1'h0;
			got_data_reg  <= 1'h0;
		end else if (stop_det) begin
			state_reg     <= ST_IDLE;
			ack_phase_reg <= 1'h0;
			ack_drive_reg <= 1'h0;
			read_selected <= 1'h0;
			got_data_reg  <= 1'h0;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					ack_drive_reg <= 1'h0;
				end
				ST_WAIT: begin
					// a matched read still owes its acknowledge pulse
					if (scl_fall & ack_phase_reg & ack_drive_reg) begin
						if (bit_cnt_reg == 4'h0)
							bit_cnt_reg <= 4'h8;
						else begin
							bit_cnt_reg   <= 4'h0;
							ack_phase_reg <= 1'h0;
							ack_drive_reg <= 1'h0;
						end
					end
				end
				ST_CTRL, ST_ADDR, ST_DATA: begin
					if (scl_rise & ~ack_phase_reg) begin
						shift_reg   <= byte_now;
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
						if (bit_cnt_reg == 4'h7) begin
							bit_cnt_reg   <= 4'h0;
							ack_phase_reg <= 1'h1;
							if (state_reg == ST_CTRL) begin
								// ack only matched, idle device
								ack_drive_reg <= ctrl_match & ~write_busy;
								if (~ctrl_match | write_busy) begin
									state_reg <= ST_WAIT;
								end else if (byte_now[0] == `TWEEW_BIT_READ) begin
									read_selected <= 1'h1;
									state_reg     <= ST_WAIT;
								end else begin
									state_reg <= ST_ADDR;
								end
							end else if (state_reg == ST_ADDR) begin
								addr_ptr       <= byte_now;
								page_base_reg  <= byte_now[7:4];
								page_valid_reg <= 16'h0000;
								wp_latched_reg <= wp_s;
								ack_drive_reg  <= 1'h1;
								state_reg      <= ST_DATA;
							end else begin
								// overwrite in place: last sixteen survive
								page_mem[addr_ptr[3:0]] <= byte_now;
								page_valid_reg[addr_ptr[3:0]] <= 1'h1;
								addr_ptr[3:0] <= addr_ptr[3:0] + 4'h1;
								got_data_reg  <= 1'h1;
								ack_drive_reg <= 1'h1;
							end
						end
					end else if (scl_fall & ack_phase_reg & ~ack_drive_reg
						& (bit_cnt_reg == 4'h0) & sda_d_reg) begin
						ack_phase_reg <= 1'h0;
					end else if (scl_fall & ack_phase_reg & ack_drive_reg) begin
						// first fall after byte: hold low through ninth pulse
						if (bit_cnt_reg == 4'h0)
							bit_cnt_reg <= 4'h8;
						else begin
							bit_cnt_reg   <= 4'h0;
							ack_phase_reg <= 1'h0;
							ack_drive_reg <= 1'h0;
						end
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// open-drain drive: only low during acknowledge
	always @(posedge clock) begin
		if (rst) begin
			sda_out <= 1'h1;
			sda_oe  <= 1'h0;
		end else begin
			sda_out <= 1'h0;
			sda_oe  <= ack_drive_reg & (bit_cnt_reg == 4'h8) & ~start_det & ~stop_det;
		end
	end

	// commit machine: stop after data starts the timed cycle
	assign push_now = (cm_reg == CM_PUSH) & page_valid_reg[cm_idx_reg] & ~wp_latched_reg;
	always @(posedge clock) begin
		if (rst) begin
			cm_reg      <= CM_IDLE;
			cm_idx_reg  <= 4'h0;
			twc_cnt_reg <= 32'h00000000;
			write_busy  <= 1'h0;
		end else begin
			case (cm_reg)
				CM_IDLE: begin
					if (stop_det & (state_reg == ST_DATA) & got_data_reg) begin
						cm_reg      <= CM_PUSH;
						cm_idx_reg  <= 4'h0;
						twc_cnt_reg <= 32'h00000000;
						write_busy  <= 1'h1;
					end
				end
				CM_PUSH: begin
					twc_cnt_reg <= twc_cnt_reg + 32'h00000001;
					// protected write sends nothing but keeps timing
					if (~push_now | buf_in_ready) begin
						cm_idx_reg <= cm_idx_reg + 4'h1;
						if (cm_idx_reg == 4'hF)
							cm_reg <= CM_TIME;
					end
				end
				CM_TIME: begin
					twc_cnt_reg <= twc_cnt_reg + 32'h00000001;
					// busy holds until the array has taken every word
					if ((twc_cnt_reg >= TWC_CYCLES - 1) & ~mem_wr_valid) begin
						cm_reg     <= CM_IDLE;
						write_busy <= 1'h0;
					end
				end
				default: begin
					cm_reg <= CM_IDLE;
				end
			endcase
		end
	end

	// buffered path to the array, stalls the commit on back-pressure
	tweew_buf2 #(.WIDTH(16)) u_buf (
		.clock     (clock),
		.rst       (rst),
		.in_data   ({page_base_reg, cm_idx_reg, page_mem[cm_idx_reg]}),
		.in_valid  (push_now),
		.in_ready  (buf_in_ready),
		.out_data  ({mem_wr_addr, mem_wr_data}),
		.out_valid (mem_wr_valid),
		.out_ready (mem_wr_ready)
	);
endmodule // tweew_slave

// File: verilog/tweew_sync.v
// two flip-flop synchroniser for one asynchronous level
`timescale 1ns/1ps
module tweew_sync (
	clock,
	rst,
	din,
	dout
);
	input  wire clock;
	input  wire rst;
	input  wire din;
	output wire dout;

	reg meta_reg;
	reg sync_reg;

	// first stage feeds only the second stage
	always @(posedge clock) begin
		if (rst) begin
			meta_reg <= 1'h1;
			sync_reg <= 1'h1;
		end else begin
			meta_reg <= din;
			sync_reg <= meta_reg;
		end
	end

	assign dout = sync_reg;
endmodule // tweew_sync
